// ---- hw/flash_guard_regs.svh ----
`ifndef FLASH_GUARD_REGS_SVH
`define FLASH_GUARD_REGS_SVH

// command opcodes
`define OP_ID_JEDEC   8'h9f
`define OP_ID_LEGACY  8'hab
`define OP_WREN       8'h06
`define OP_WRDI       8'h04
`define OP_PDOWN      8'hb9
`define OP_SSE_A      8'hd7
`define OP_SSE_B      8'h20
`define OP_SE         8'hd8
`define OP_CE         8'hc7
`define OP_PP         8'h02
`define OP_WRSR       8'h01
`define OP_RDSR       8'h05

// byte count before legacy id data (opcode + 3)
`define LEGACY_HDR_BYTES 4'h4
// status write: opcode + 1 data byte allowed
`define WRSR_MAX_BYTES   4'h2
// page program: opcode + 3 address bytes before data
`define PP_HDR_BYTES     4'h4

// power-up read / write waits
`define T_PU_READ_US     100
`define T_PU_WRITE_MS    10
`define CLK_MHZ          50

// internal write busy time in cycles (arbitrary model length)
`define BUSY_CYCLES      16'h0400

`endif

// ---- hw/flash_guard_pkg.sv ----
package flash_guard_pkg;
  typedef enum logic [1:0] {
    ST_CMD,
    ST_LEGACY,
    ST_IDOUT,
    ST_DISCARD
  } cmd_state_e;

  typedef enum logic [2:0] {
    WK_NONE,
    WK_ERASE,
    WK_PROG,
    WK_WRSR,
    WK_OTHER
  } wr_kind_e;

  typedef struct packed {
    logic [7:0] mfr;
    logic [7:0] dev;
  } id_pair_s;
endpackage

// ---- hw/flash_id_hold_guard.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "flash_guard_regs.svh"

module flash_id_hold_guard
  import flash_guard_pkg::*;
#(
  parameter logic [7:0] MFR_CODE   = 8'h5a, // arbitrary value
  parameter logic [7:0] DEV_CODE   = 8'ha5, // arbitrary value
  parameter int         PU_WR_CYC  = `T_PU_WRITE_MS * 1000 * `CLK_MHZ
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic cs_n,
  input  wire logic sck,
  input  wire logic si,
  input  wire logic suspend_n,
  output var  logic so_o,
  output var  logic so_oe,
  output var  logic wren_latch,
  output var  logic busy,
  output var  logic power_down,
  output var  logic suspended
);

  localparam id_pair_s IDS = '{mfr: MFR_CODE, dev: DEV_CODE};

  // two-flop synchronisers for cs_n, sck, si and suspend_n (rst_n is not synchronised)
  logic [3:0] s1_q;
  logic [3:0] s2_q;
  logic [3:0] s3_q;
  always_ff @(posedge clk_sys) begin
    s1_q <= {cs_n, sck, si, suspend_n};
    s2_q <= s1_q;
    s3_q <= s2_q;
  end

  logic cs_n_s;
  logic sck_s;
  logic si_s;
  logic sus_s;
  assign cs_n_s = s2_q[3];
  assign sck_s  = s2_q[2];
  assign si_s   = s2_q[1];
  assign sus_s  = s2_q[0];
  logic sck_rise;
  logic sck_fall;
  logic cs_rise;
  logic sus_fall;
  logic sus_rise;
  assign sck_rise = sck_s & ~s3_q[2];
  assign sck_fall = ~sck_s & s3_q[2];
  assign cs_rise  = cs_n_s & ~s3_q[3];
  assign sus_fall = ~sus_s & s3_q[0];
  assign sus_rise = sus_s & ~s3_q[0];

  function automatic logic is_write_op(input logic [7:0] op);
    return op == `OP_SSE_A || op == `OP_SSE_B || op == `OP_SE || op == `OP_CE ||
           op == `OP_PP || op == `OP_WRSR;
  endfunction

  cmd_state_e  st_q, st_d;
  logic [2:0]  bit_q, bit_d;
  logic [3:0]  bytes_q, bytes_d;
  logic [7:0]  sh_q, sh_d;
  logic [7:0]  op_q, op_d;
  logic [7:0]  tx_q, tx_d;
  logic        sel_q, sel_d;
  logic        so_q, so_d;
  logic        oe_q, oe_d;
  logic        sus_q, sus_d;
  logic        wen_q, wen_d;
  logic        pd_q, pd_d;
  logic [15:0] busy_q, busy_d;
  logic        busy_flag_q, busy_flag_d;
  logic        pu_ok_q, pu_ok_d;
  logic [31:0] pu_cnt_q, pu_cnt_d;

  logic [7:0] byte_in;
  logic       byte_done;
  logic       active;
  assign byte_in   = {sh_q[6:0], si_s};
  assign active    = ~cs_n_s & ~sus_q;
  assign byte_done = active & sck_rise & (bit_q == 3'h7);

  always_comb begin
    st_d     = st_q;
    bit_d    = bit_q;
    bytes_d  = bytes_q;
    sh_d     = sh_q;
    op_d     = op_q;
    tx_d     = tx_q;
    sel_d    = sel_q;
    so_d     = so_q;
    oe_d     = oe_q;
    sus_d    = sus_q;
    wen_d    = wen_q;
    pd_d     = pd_q;
    busy_d   = (busy_q != 16'h0000) ? busy_q - 16'h0001 : busy_q;
    pu_ok_d  = pu_ok_q | (pu_cnt_q >= 32'(PU_WR_CYC));
    pu_cnt_d = pu_ok_q ? pu_cnt_q : pu_cnt_q + 32'h1;
    if (~cs_n_s && sus_fall && !sck_s) begin
      sus_d = 1'b1;
      oe_d  = 1'b0;
    end else if (sus_rise) begin
      sus_d = 1'b0;
      if (sus_q && ~cs_n_s && st_q == ST_IDOUT) begin
        oe_d = 1'b1;
      end
    end
    if (active && sck_rise) begin
      sh_d  = byte_in;
      bit_d = bit_q + 3'h1;
    end
    if (byte_done) begin
      if (bytes_q != 4'hf) begin
        bytes_d = bytes_q + 4'h1;
      end
      if (bytes_q == 4'h0) begin
        op_d = byte_in;
        st_d = ST_DISCARD;
        if (byte_in == `OP_ID_LEGACY) begin
          pd_d = 1'b0;
        end
        if (busy_q != 16'h0000) begin
          st_d = ST_DISCARD;
        end else if (byte_in == `OP_ID_LEGACY) begin
          st_d = ST_LEGACY;
        end else if (pd_q) begin
          st_d = ST_DISCARD;
        end else if (byte_in == `OP_ID_JEDEC) begin
          st_d  = ST_IDOUT;
          sel_d = 1'b0;
        end else begin
          st_d = ST_CMD;
        end
      end else if (st_q == ST_LEGACY && bytes_q == `LEGACY_HDR_BYTES - 4'h1) begin
        sel_d = byte_in[0];
        st_d  = ST_IDOUT;
      end else if (st_q == ST_IDOUT) begin
        sel_d = ~sel_q;
      end
    end
    if (active && sck_fall && st_q == ST_IDOUT) begin
      oe_d = 1'b1;
      if (bit_q == 3'h0) begin
        tx_d = sel_q ? IDS.dev : IDS.mfr;
        so_d = sel_q ? IDS.dev[7] : IDS.mfr[7];
      end else begin
        so_d = tx_q[3'h7 - bit_q];
      end
    end
    if (sus_d) begin
      oe_d = 1'b0;
    end
    if (cs_rise) begin
      if (st_q == ST_CMD && bit_q == 3'h0 && bytes_q != 4'h0 && busy_q == 16'h0000 && !pd_q) begin
        if (op_q == `OP_WREN && bytes_q == 4'h1) begin
          wen_d = 1'b1;
        end else if (op_q == `OP_WRDI && bytes_q == 4'h1) begin
          wen_d = 1'b0;
        end else if (op_q == `OP_PDOWN && bytes_q == 4'h1) begin
          pd_d = 1'b1;
        end else if (is_write_op(op_q) && wen_q && pu_ok_q &&
                     !(op_q == `OP_WRSR && bytes_q > `WRSR_MAX_BYTES) &&
                     !(op_q == `OP_PP && bytes_q <= `PP_HDR_BYTES)) begin
          busy_d = `BUSY_CYCLES;
          wen_d  = 1'b0;
        end
      end
      // cs rise clears suspend and parser
      st_d    = ST_CMD;
      bit_d   = 3'h0;
      bytes_d = 4'h0;
      sus_d   = 1'b0;
      oe_d    = 1'b0;
      so_d    = 1'b0;
    end
    if (cs_n_s) begin
      oe_d = 1'b0;
    end
    busy_flag_d = busy_d != 16'h0000;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_q     <= ST_CMD;
      bit_q    <= 3'h0;
      bytes_q  <= 4'h0;
      sh_q     <= 8'h00;
      op_q     <= 8'h00;
      tx_q     <= 8'h00;
      sel_q    <= 1'b0;
      so_q     <= 1'b0;
      oe_q     <= 1'b0;
      sus_q    <= 1'b0;
      wen_q    <= 1'b0;
      pd_q     <= 1'b0;
      busy_q   <= 16'h0000;
      busy_flag_q <= 1'b0;
      pu_ok_q  <= 1'b0;
      pu_cnt_q <= 32'h0;
    end else begin
      st_q     <= st_d;
      bit_q    <= bit_d;
      bytes_q  <= bytes_d;
      sh_q     <= sh_d;
      op_q     <= op_d;
      tx_q     <= tx_d;
      sel_q    <= sel_d;
      so_q     <= so_d;
      oe_q     <= oe_d;
      sus_q    <= sus_d;
      wen_q    <= wen_d;
      pd_q     <= pd_d;
      busy_q   <= busy_d;
      busy_flag_q <= busy_flag_d;
      pu_ok_q  <= pu_ok_d;
      pu_cnt_q <= pu_cnt_d;
    end
  end

  assign so_o       = so_q;
  assign so_oe      = oe_q;
  assign wren_latch = wen_q;
  assign busy       = busy_flag_q;
  assign power_down = pd_q;
  assign suspended  = sus_q;

  chk_suspend_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sus_q |-> !oe_q) else $error("so driven while suspended");
  chk_cs_reset: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cs_rise |=> (st_q == ST_CMD && bytes_q == 4'h0 && !sus_q)) else $error("cs rise no reset");
  chk_busy_noid: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (byte_done && bytes_q == 4'h0 && busy_q != 16'h0000) |=> st_q == ST_DISCARD)
    else $error("id accepted while busy");
  chk_jedec_start: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (byte_done && bytes_q == 4'h0 && byte_in == `OP_ID_JEDEC && busy_q == 16'h0000 && !pd_q)
    |=> (st_q == ST_IDOUT && !sel_q)) else $error("9f not mfr first");
  chk_legacy_sel: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (byte_done && st_q == ST_LEGACY && bytes_q == 4'h3) |=> sel_q == $past(si_s))
    else $error("wrong start code");
  chk_alternate: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (byte_done && st_q == ST_IDOUT) |=> sel_q != $past(sel_q)) else $error("no alternation");
  chk_wen_keep: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (cs_rise && bit_q != 3'h0) |=> $stable(wen_q)) else $error("latch changed");
  chk_wrsr_reject: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (cs_rise && op_q == `OP_WRSR && bytes_q > `WRSR_MAX_BYTES && busy_q == 16'h0000)
    |=> busy_q == 16'h0000) else $error("long wrsr accepted");
  chk_offbyte_drop: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (cs_rise && bit_q != 3'h0 && busy_q == 16'h0000)
    |=> busy_q == 16'h0000) else $error("off-byte write accepted");
  chk_pp_nodata: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (cs_rise && op_q == `OP_PP && bytes_q <= `PP_HDR_BYTES && busy_q == 16'h0000)
    |=> busy_q == 16'h0000) else $error("empty program accepted");
  chk_abh_wake: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (byte_done && bytes_q == 4'h0 && byte_in == `OP_ID_LEGACY) |=> !pd_q) else $error("no wake");

endmodule

`default_nettype wire

// ---- bench/spi_host_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module spi_host_model (
  input  wire logic clk_sys,
  input  wire logic so_o,
  input  wire logic so_oe,
  output var  logic cs_n,
  output var  logic sck,
  output var  logic si,
  output var  logic suspend_n
);
  int   half = 4;
  logic last_q = 1'b0;
  logic oe_seen = 1'b0;
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    suspend_n = 1'b1;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic bits(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      si = tx[i];
      wait_clk(half);
      sck = 1'b1;
      rx[i] = so_oe ? so_o : ~last_q;
      last_q = rx[i];
      oe_seen = oe_seen | so_oe;
      wait_clk(half);
      sck = 1'b0;
    end
  endtask
  task automatic open_frame();
    cs_n = 1'b0;
    oe_seen = 1'b0;
    wait_clk(half);
  endtask
  task automatic close_frame();
    cs_n = 1'b1;
    si = ~si;
    wait_clk(10);
  endtask
  task automatic set_susp(input logic v);
    suspend_n = v;
    wait_clk(6);
  endtask
endmodule
`default_nettype wire

// ---- bench/serial_flash_id_hold_guard_bench.sv ----
`timescale 1ns/10ps
`default_nettype none
module serial_flash_id_hold_guard_bench;
  import flash_guard_pkg::*;
  localparam logic [7:0] MFR = 8'h5a;
  localparam logic [7:0] DEV = 8'ha5;
  logic       clk_sys;
  logic       rst_n;
  logic       cs_n;
  logic       sck;
  logic       si;
  logic       suspend_n;
  logic       so_o;
  logic       so_oe;
  logic       wren_latch;
  logic       busy;
  logic       power_down;
  logic       suspended;
  logic [7:0] r;
  int         bad_count = 0;
  int         n_checks = 0;
  flash_id_hold_guard #(.PU_WR_CYC(20)) flash_id_hold_guard_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .cs_n(cs_n), .sck(sck), .si(si), .suspend_n(suspend_n),
    .so_o(so_o), .so_oe(so_oe), .wren_latch(wren_latch), .busy(busy), .power_down(power_down),
    .suspended(suspended));
  spi_host_model spi_host_model_i (
    .clk_sys(clk_sys), .so_o(so_o), .so_oe(so_oe), .cs_n(cs_n), .sck(sck), .si(si),
    .suspend_n(suspend_n));
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask
  task automatic xb(input logic [7:0] tx);
    spi_host_model_i.bits(tx, 8, r);
  endtask
  task automatic frame1(input logic [7:0] op);
    spi_host_model_i.open_frame();
    xb(op);
  endtask
  task automatic t_writes();
    chk1(wren_latch, 1'b0);
    frame1(8'h06);
    spi_host_model_i.close_frame();
    frame1(8'h01);
    xb(8'h00);
    xb(8'h00);
    spi_host_model_i.close_frame();
    chk1(busy, 1'b0);
    chk1(wren_latch, 1'b1);
    frame1(8'hc7);
    spi_host_model_i.bits(8'h00, 3, r);
    spi_host_model_i.close_frame();
    chk1(busy, 1'b0);
    frame1(8'h02);
    repeat (3) xb(8'h00);
    spi_host_model_i.close_frame();
    chk1(busy, 1'b0);
    frame1(8'h02);
    repeat (4) xb(8'h00);
    spi_host_model_i.bits(8'h00, 4, r);
    spi_host_model_i.close_frame();
    chk1(busy, 1'b0);
    chk1(wren_latch, 1'b1);
    frame1(8'h01);
    xb(8'h00);
    spi_host_model_i.close_frame();
    chk1(busy, 1'b1);
    frame1(8'h9f);
    xb(8'h00);
    spi_host_model_i.close_frame();
    chk1(spi_host_model_i.oe_seen, 1'b0);
    for (int i = 0; i < 3000 && busy !== 1'b0; i++) spi_host_model_i.wait_clk(1);
    chk1(busy, 1'b0);
  endtask
  task automatic t_pdown();
    frame1(8'hb9);
    spi_host_model_i.close_frame();
    chk1(power_down, 1'b1);
    frame1(8'h9f);
    xb(8'h00);
    spi_host_model_i.close_frame();
    chk1(spi_host_model_i.oe_seen, 1'b0);
    frame1(8'hab);
    spi_host_model_i.close_frame();
    chk1(power_down, 1'b0);
  endtask
  task automatic t_jedec();
    frame1(8'h9f);
    for (int i = 0; i < 4; i++) begin
      xb(8'h00);
      chk8(r, i[0] ? DEV : MFR);
    end
    chk1(so_oe, 1'b1);
    spi_host_model_i.close_frame();
    chk1(so_oe, 1'b0);
  endtask
  task automatic t_legacy(input logic sel, input int hf);
    spi_host_model_i.half = hf;
    frame1(8'hab);
    xb(8'h00);
    xb(8'h00);
    xb({7'h00, sel});
    chk1(spi_host_model_i.oe_seen, 1'b0);
    for (int i = 0; i < 3; i++) begin
      xb(8'hff);
      chk8(r, (i[0] ^ sel) ? DEV : MFR);
    end
    spi_host_model_i.close_frame();
    spi_host_model_i.half = 4;
  endtask
  task automatic t_suspend();
    spi_host_model_i.set_susp(1'b0);
    chk1(suspended, 1'b0);
    spi_host_model_i.set_susp(1'b1);
    frame1(8'h9f);
    xb(8'h00);
    chk8(r, MFR);
    spi_host_model_i.set_susp(1'b0);
    chk1(suspended, 1'b1);
    chk1(so_oe, 1'b0);
    xb(8'h9f);
    spi_host_model_i.set_susp(1'b1);
    chk1(suspended, 1'b0);
    xb(8'h00);
    chk8(r, DEV);
    spi_host_model_i.set_susp(1'b0);
    spi_host_model_i.close_frame();
    chk1(suspended, 1'b0);
    spi_host_model_i.set_susp(1'b1);
    frame1(8'h9f);
    xb(8'h00);
    chk8(r, MFR);
    spi_host_model_i.close_frame();
  endtask
  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    repeat (8) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (24) @(negedge clk_sys);
    t_writes();
    t_pdown();
    t_jedec();
    t_legacy(1'b0, 4);
    t_legacy(1'b1, 8);
    t_suspend();
    end_of_test();
  end
  initial begin
    #1000000;
    bad_count++;
    end_of_test();
  end
endmodule
`default_nettype wire
